//--- design/clear_complement_compare_ops.v
// Purpose: Executes six core operations against an accumulator, a 64-word
//          register file, the zero/carry flags and the watchdog.
// Assumes: Software issues operations by writing the command register.
// Notes:   Summary of operation follows.
//
// Summary of operation
// - Clear accumulator loads zero into it and sets zero flag, two cycles.
// - Clear watchdog zeroes counter, and prescaler when assigned to it.
// - Clear watchdog sets time-out and power-down status bits to one only.
// - Clear register zeroes addressed register 0..63, sets zero flag.
// - Complement inverts register; dest 0 to accumulator, 1 back; Z only.
// - Compare does register minus accumulator, updates Z and C, no writes.
// - Decrement subtracts one; dest 0 to accumulator, 1 back; Z only.
`timescale 1ns/1ps
`include "ccc_ops_map.vh"
module clear_complement_compare_ops (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // AXI4-Lite write address
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   // AXI4-Lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   // AXI4-Lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read address
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   // AXI4-Lite read data
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // Status pins
   output reg timeout_status_n,
   output reg powerdown_status_n
);
   localparam ST_IDLE = 3'b001;
   localparam ST_FETCH = 3'b010;
   localparam ST_EXEC = 3'b100;

   reg [2:0] state_q;
   reg [7:0] accumulator;
   reg zero_q;
   reg carry_q;
   reg psa_q;
   reg wdt_en_q;
   reg [7:0] watchdog_counter;
   reg [7:0] shared_prescaler;
   reg [5:0] file_addr_q;
   reg [9:0] cmd_q;
   reg [7:0] aw_addr_q;
   reg aw_held_q;
   reg [31:0] w_data_q;
   reg [3:0] w_strb_q;
   reg w_held_q;
   reg rd_pend_q;

   wire idle = state_q[0];
   wire [2:0] op = cmd_q[`CMD_OP_MSB:`CMD_OP_LSB];
   wire dest_reg = cmd_q[`CMD_DEST_BIT];
   wire [5:0] op_addr = cmd_q[`CMD_ADDR_MSB:`CMD_ADDR_LSB];
   wire [7:0] mem_rdata;

   // Write transaction performed once both halves are held
   wire wr_go = aw_held_q && w_held_q && !s_axi_bvalid && idle;
   wire [7:0] wr_addr = {aw_addr_q[7:2], 2'b00};
   wire wr_lane0 = w_strb_q[0];
   wire ar_go = s_axi_arvalid && s_axi_arready;
   wire [7:0] rd_addr = {s_axi_araddr[7:2], 2'b00};

   // Results of the operation in execute
   wire [7:0] comp_res = ~mem_rdata;
   wire [7:0] dec_res = mem_rdata - 8'h01;
   wire [8:0] cmp_diff = {1'b0, mem_rdata} - {1'b0, accumulator};

   // Watchdog tick and overflow
   wire wdt_tick = psa_q ? (shared_prescaler == `PRESCALE_TOP) : 1'b1;
   wire wdt_over = wdt_en_q && wdt_tick && (watchdog_counter == 8'hFF);
   wire exec_clr_wdt = state_q[2] && (op == `OP_CLEAR_WDT);

   // Register file ports
   reg mem_we;
   reg [5:0] mem_waddr;
   reg [7:0] mem_wdata;
   wire [5:0] mem_raddr = state_q[1] ? op_addr : file_addr_q;

   always @* begin
      mem_we = 1'b0;
      mem_waddr = op_addr;
      mem_wdata = `ZERO_BYTE;
      if (state_q[2]) begin
         case (op)
            `OP_CLEAR_REG: begin
               mem_we = 1'b1;
            end
            `OP_COMPLEMENT: begin
               mem_we = dest_reg;
               mem_wdata = comp_res;
            end
            `OP_DECREMENT: begin
               mem_we = dest_reg;
               mem_wdata = dec_res;
            end
            default: begin
               mem_we = 1'b0;
            end
         endcase
      end else if (wr_go && wr_lane0 && wr_addr == `OFS_FILE_DATA) begin
         mem_we = 1'b1;
         mem_waddr = file_addr_q;
         mem_wdata = w_data_q[7:0];
      end
   end

   file_reg_mem u_mem (
      .aclk(aclk),
      .we(mem_we),
      .waddr(mem_waddr),
      .wdata(mem_wdata),
      .raddr(mem_raddr),
      .rdata(mem_rdata)
   );

   // Write address and data channels, taken in either order
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h00000000;
         w_strb_q <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_held_q && !s_axi_awready;
         s_axi_wready <= !w_held_q && !s_axi_wready;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_go) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wr_addr > `OFS_WATCHDOG) ?
               `RESP_SLVERR : `RESP_OKAY;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Read channel
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `RESP_OKAY;
         rd_pend_q <= 1'b0;
      end else begin
         // Not offered as a command starts: operand fetch owns the read port
         s_axi_arready <= idle && !wr_go && !s_axi_rvalid && !rd_pend_q &&
            !s_axi_arready;
         if (ar_go) begin
            s_axi_arready <= 1'b0;
            s_axi_rresp <= (rd_addr > `OFS_WATCHDOG) ?
               `RESP_SLVERR : `RESP_OKAY;
            s_axi_rdata <= 32'h00000000;
            case (rd_addr)
               `OFS_COMMAND: begin
                  s_axi_rdata[9:0] <= cmd_q;
               end
               `OFS_ACC: begin
                  s_axi_rdata[7:0] <= accumulator;
               end
               `OFS_STATUS: begin
                  s_axi_rdata[`ST_ZERO_BIT] <= zero_q;
                  s_axi_rdata[`ST_CARRY_BIT] <= carry_q;
                  s_axi_rdata[`ST_PD_N_BIT] <= powerdown_status_n;
                  s_axi_rdata[`ST_TO_N_BIT] <= timeout_status_n;
                  s_axi_rdata[`ST_BUSY_BIT] <= !idle;
               end
               `OFS_CONTROL: begin
                  s_axi_rdata[`CTL_PSA_BIT] <= psa_q;
                  s_axi_rdata[`CTL_WDT_EN_BIT] <= wdt_en_q;
               end
               `OFS_FILE_ADDR: begin
                  s_axi_rdata[5:0] <= file_addr_q;
               end
               `OFS_WATCHDOG: begin
                  s_axi_rdata[15:0] <= {shared_prescaler, watchdog_counter};
               end
               default: begin
                  s_axi_rdata <= 32'h00000000;
               end
            endcase
            if (rd_addr == `OFS_FILE_DATA) begin
               rd_pend_q <= 1'b1;
            end else begin
               s_axi_rvalid <= 1'b1;
            end
         end
         if (rd_pend_q) begin
            rd_pend_q <= 1'b0;
            s_axi_rdata[7:0] <= mem_rdata;
            s_axi_rvalid <= 1'b1;
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Sequencer: fetch the operand, then execute in one cycle
   always @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= ST_IDLE;
         cmd_q <= 10'h000;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (wr_go && wr_addr == `OFS_COMMAND &&
                   w_strb_q[1:0] == 2'h3 &&
                   w_data_q[`CMD_OP_MSB:`CMD_OP_LSB] <= `OP_DECREMENT) begin
                  cmd_q <= w_data_q[9:0];
                  state_q <= ST_FETCH;
               end
            end
            ST_FETCH: begin
               state_q <= ST_EXEC;
            end
            ST_EXEC: begin
               state_q <= ST_IDLE;
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Accumulator, flags, control and file address
   always @(posedge aclk) begin
      if (!aresetn) begin
         accumulator <= `RST_ACC;
         zero_q <= 1'b0;
         carry_q <= 1'b0;
         psa_q <= 1'b0;
         wdt_en_q <= 1'b0;
         file_addr_q <= 6'h00;
      end else if (state_q[2]) begin
         case (op)
            `OP_CLEAR_ACC: begin
               accumulator <= `ZERO_BYTE;
               zero_q <= 1'b1;
            end
            `OP_CLEAR_REG: begin
               zero_q <= 1'b1;
            end
            `OP_COMPLEMENT: begin
               if (!dest_reg) begin
                  accumulator <= comp_res;
               end
               zero_q <= (comp_res == `ZERO_BYTE);
            end
            `OP_COMPARE: begin
               zero_q <= (cmp_diff[7:0] == `ZERO_BYTE);
               carry_q <= !cmp_diff[8];
            end
            `OP_DECREMENT: begin
               if (!dest_reg) begin
                  accumulator <= dec_res;
               end
               zero_q <= (dec_res == `ZERO_BYTE);
            end
            default: begin
               zero_q <= zero_q;
            end
         endcase
      end else if (wr_go && wr_lane0) begin
         case (wr_addr)
            `OFS_ACC: begin
               accumulator <= w_data_q[7:0];
            end
            `OFS_STATUS: begin
               zero_q <= w_data_q[`ST_ZERO_BIT];
               carry_q <= w_data_q[`ST_CARRY_BIT];
            end
            `OFS_CONTROL: begin
               psa_q <= w_data_q[`CTL_PSA_BIT];
               wdt_en_q <= w_data_q[`CTL_WDT_EN_BIT];
            end
            `OFS_FILE_ADDR: begin
               file_addr_q <= w_data_q[5:0];
            end
            default: begin
               file_addr_q <= file_addr_q;
            end
         endcase
      end
   end

   // Watchdog counter, shared prescaler and the two status bits
   always @(posedge aclk) begin
      if (!aresetn) begin
         watchdog_counter <= `RST_WDT;
         shared_prescaler <= `RST_PRESCALE;
         timeout_status_n <= 1'b1;
         powerdown_status_n <= 1'b1;
      end else begin
         shared_prescaler <= shared_prescaler + 8'h01;
         if (wdt_en_q && wdt_tick) begin
            watchdog_counter <= watchdog_counter + 8'h01;
         end
         if (wdt_over) begin
            timeout_status_n <= 1'b0;
         end
         if (idle && wr_go && wr_lane0 && wr_addr == `OFS_CONTROL &&
             w_data_q[`CTL_SLEEP_BIT]) begin
            powerdown_status_n <= 1'b0;
         end
         if (exec_clr_wdt) begin
            watchdog_counter <= `RST_WDT;
            if (psa_q) begin
               shared_prescaler <= `RST_PRESCALE;
            end
            timeout_status_n <= 1'b1;
            powerdown_status_n <= 1'b1;
         end
      end
   end
endmodule

//--- design/ccc_ops_map.vh
// Purpose: Offsets, field positions, encodings and reset values of the
//          clear/complement/compare execution block.
// Assumes: AXI4-Lite byte addresses, one aligned 32-bit word per register.
// Notes:   Definitions only.
`ifndef CCC_OPS_MAP_VH
`define CCC_OPS_MAP_VH

// Register byte offsets
`define OFS_COMMAND   8'h00
`define OFS_ACC       8'h04
`define OFS_STATUS    8'h08
`define OFS_CONTROL   8'h0C
`define OFS_FILE_ADDR 8'h10
`define OFS_FILE_DATA 8'h14
`define OFS_WATCHDOG  8'h18

// Command word fields
`define CMD_OP_MSB    2
`define CMD_OP_LSB    0
`define CMD_DEST_BIT  3
`define CMD_ADDR_MSB  9
`define CMD_ADDR_LSB  4

// Operation codes
`define OP_CLEAR_ACC  3'h0
`define OP_CLEAR_WDT  3'h1
`define OP_CLEAR_REG  3'h2
`define OP_COMPLEMENT 3'h3
`define OP_COMPARE    3'h4
`define OP_DECREMENT  3'h5

// Status fields
`define ST_ZERO_BIT   0
`define ST_CARRY_BIT  1
`define ST_PD_N_BIT   2
`define ST_TO_N_BIT   3
`define ST_BUSY_BIT   4

// Control fields
`define CTL_PSA_BIT   0
`define CTL_WDT_EN_BIT 1
`define CTL_SLEEP_BIT 2

// Reset values and constants
`define RST_ACC       8'h00
`define RST_WDT       8'h00
`define RST_PRESCALE  8'h00
`define PRESCALE_TOP  8'hFF
`define ZERO_BYTE     8'h00

// AXI responses
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2

`endif

//--- design/file_reg_mem.v
// Purpose: 64 x 8 register file with one write and one read port.
// Assumes: Read data appear one clock after the address, from a register.
// Notes:   A read and write of the same word in one cycle returns old data.
`timescale 1ns/1ps
module file_reg_mem (
   // Clock
   input wire aclk,
   // Write port
   input wire we,
   input wire [5:0] waddr,
   input wire [7:0] wdata,
   // Read port
   input wire [5:0] raddr,
   output reg [7:0] rdata
);
   reg [7:0] mem [0:63];

   always @(posedge aclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule

//--- bench/ccc_ops_properties.sv
// Purpose: Port checks for clear_complement_compare_ops.
// Assumes: One write and one read under way at a time.
// Notes: Reads are not taken while an op runs.
`timescale 1ns/1ps
`include "ccc_ops_map.vh"
module ccc_ops_properties (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Write channels
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // Read channels
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Status pins
   input wire logic timeout_status_n,
   input wire logic powerdown_status_n
);
   logic [7:0] wa_q, ra_q;
   logic [2:0] op_q, last_q;
   logic ok_q, bv_q;
   wire done = s_axi_bvalid && !bv_q;
   wire cmd = done && wa_q[7:2] == 6'h00 && ok_q;

   // Last op is forgotten on any other write
   always @(posedge aclk) begin
      bv_q <= s_axi_bvalid && aresetn;
      if (!aresetn) last_q <= 3'h7;
      else if (done) last_q <= cmd ? op_q : 3'h7;
      if (s_axi_awvalid && s_axi_awready) wa_q <= s_axi_awaddr;
      if (s_axi_arvalid && s_axi_arready) ra_q <= s_axi_araddr;
      if (s_axi_wvalid && s_axi_wready) begin
         op_q <= s_axi_wdata[2:0];
         ok_q <= &s_axi_wstrb[1:0] && s_axi_wdata[2:0] <= 3'h5;
      end
   end

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence aw_take;
      s_axi_awvalid && s_axi_awready;
   endsequence
   sequence clr_wdt_go;
      cmd && op_q == `OP_CLEAR_WDT;
   endsequence

   write_answer_a: assert property (aw_take |-> ##[1:6] s_axi_bvalid)
      else $error("write got no response");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready
      |-> ##[1:2] s_axi_rvalid) else $error("read got no data");
   resp_held_a: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   data_held_a: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   resp_code_a: assert property (s_axi_bvalid |-> s_axi_bresp ==
      (wa_q > 8'h18 ? `RESP_SLVERR : `RESP_OKAY))
      else $error("wrong write response code");
   wdt_pins_set_a: assert property (
      clr_wdt_go |-> ##[1:4] timeout_status_n && powerdown_status_n)
      else $error("status pins not set by watchdog clear");
   acc_clear_a: assert property (
      s_axi_rvalid && ra_q == `OFS_ACC && last_q == `OP_CLEAR_ACC
      |-> s_axi_rdata == 32'h00000000) else $error("accumulator not zero");
   zero_flag_set_a: assert property (
      s_axi_rvalid && ra_q == `OFS_STATUS && (last_q == `OP_CLEAR_REG
      || last_q == `OP_CLEAR_ACC) |-> s_axi_rdata[`ST_ZERO_BIT])
      else $error("zero flag not set by clear");
   reset_idle_a: assert property (disable iff (1'b0) !aresetn
      |=> !s_axi_bvalid && !s_axi_rvalid && timeout_status_n
      && powerdown_status_n) else $error("outputs not idle after reset");
endmodule

//--- bench/test_clear_complement_compare_ops.sv
// Purpose: Self-checking bench for clear_complement_compare_ops.
// Assumes: Register file words are written before they are used.
// Notes: A local model notes each read result; a monitor compares.
`timescale 1ns/1ps
`include "ccc_ops_map.vh"
module test_clear_complement_compare_ops;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic timeout_status_n, powerdown_status_n, z_m, c_m, pd_m, to_m;
   logic [7:0] s_axi_awaddr, s_axi_araddr, acc_m, bnd;
   logic [7:0] rf_m [64];
   logic [31:0] s_axi_wdata, s_axi_rdata, seed, v;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [2:0] o;
   logic [63:0] ev;
   logic [63:0] exp_r [$];
   logic [1:0] exp_b [$];
   logic [1:0] exp_rr [$];
   int n_mismatch, checks, cycles, i, k;

   clear_complement_compare_ops i_dut (.aclk, .aresetn, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .timeout_status_n, .powerdown_status_n);

   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end

   task automatic final_report();
      if (n_mismatch == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_mismatch++;
         final_report();
      end
   end

   // Monitor: every answer is matched with the oldest noted result
   always @(posedge aclk) begin
      if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
         ev = exp_r.pop_front();
         check(s_axi_rdata & ev[63:32], ev[31:0]);
         check({30'h0, s_axi_rresp}, {30'h0, exp_rr.pop_front()});
      end
      if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
         check({30'h0, s_axi_bresp}, {30'h0, exp_b.pop_front()});
   end

   function automatic logic [31:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction

   function automatic logic [31:0] stat();
      return {28'h0, to_m, pd_m, c_m, z_m};
   endfunction

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s = 4'hF);
      @(posedge aclk);
      exp_b.push_back(a > 8'h18 ? `RESP_SLVERR : `RESP_OKAY);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e,
      input logic [31:0] m = 32'hFFFFFFFF);
      @(posedge aclk);
      exp_r.push_back({m, e});
      exp_rr.push_back(a > 8'h18 ? `RESP_SLVERR : `RESP_OKAY);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
   endtask

   task automatic do_reset();
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      acc_m = 8'h00;
      {z_m, c_m, pd_m, to_m} = 4'h3;
   endtask

   task automatic set_reg(input logic [5:0] r, input logic [7:0] d);
      wr(`OFS_FILE_ADDR, {26'h0, r});
      wr(`OFS_FILE_DATA, {24'h0, d});
      rf_m[r] = d;
   endtask

   task automatic op(input logic [2:0] c, input logic d,
      input logic [5:0] r);
      logic [7:0] res;
      wr(`OFS_COMMAND, {22'h0, r, d, c});
      res = 8'h00;
      if (c == `OP_COMPLEMENT) res = ~rf_m[r];
      if (c == `OP_COMPARE) res = rf_m[r] - acc_m;
      if (c == `OP_DECREMENT) res = rf_m[r] - 8'h01;
      if (c == `OP_COMPARE) c_m = rf_m[r] >= acc_m;
      if (c != `OP_CLEAR_WDT) z_m = res == 8'h00;
      if (c == `OP_CLEAR_WDT) {pd_m, to_m} = 2'h3;
      if (c == `OP_CLEAR_ACC || (c[0] && c != 3'h1 && !d)) acc_m = res;
      if (c == `OP_CLEAR_REG || (c[0] && c != 3'h1 && d)) rf_m[r] = res;
      rd(`OFS_ACC, {24'h0, acc_m});
      rd(`OFS_STATUS, stat());
      wr(`OFS_FILE_ADDR, {26'h0, r});
      rd(`OFS_FILE_DATA, {24'h0, rf_m[r]});
   endtask

   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
      {s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
      {s_axi_arvalid, s_axi_rready, aresetn} = '0;
      seed = 32'hE4C3;
      do_reset();
      for (i = 0; i < 64; i++) begin
         v = rnd();
         set_reg(i[5:0], v[7:0]);
      end
      wr(8'h1C, 32'h0);
      rd(8'h20, 32'h0);
      // A command without both low byte lanes is ignored
      wr(`OFS_ACC, 32'h5A);
      wr(`OFS_COMMAND, 32'h0, 4'hE);
      rd(`OFS_ACC, 32'h5A);
      // Random flags and operands, later with boundary register values
      for (k = 0; k < 60; k++) begin
         v = rnd();
         o = 3'(k % 6);
         bnd = v[17:16] == 2'h0 ? v[7:0] : 8'hFF;
         if (^v[17:16]) bnd = {7'h0, v[17]};
         wr(`OFS_ACC, {24'h0, v[7:0]});
         wr(`OFS_STATUS, {30'h0, v[9:8]});
         acc_m = v[7:0];
         {c_m, z_m} = v[9:8];
         set_reg(v[15:10], k < 30 ? v[31:24] : bnd);
         if (o == `OP_CLEAR_WDT) begin
            wr(`OFS_CONTROL, 32'h4);
            pd_m = 1'b0;
            rd(`OFS_STATUS, stat());
         end
         op(o, v[18], v[15:10]);
      end
      // Let the watchdog overflow, then clear it
      wr(`OFS_CONTROL, 32'h2);
      repeat (300) @(posedge aclk);
      wr(`OFS_CONTROL, 32'h0);
      to_m = 1'b0;
      rd(`OFS_STATUS, stat());
      op(`OP_CLEAR_WDT, 1'b0, 6'h00);
      rd(`OFS_WATCHDOG, 32'h0, 32'hFF);
      // Prescaler assigned to the watchdog restarts from zero on a clear
      wr(`OFS_CONTROL, 32'h1);
      wr(`OFS_COMMAND, {29'h0, `OP_CLEAR_WDT});
      rd(`OFS_WATCHDOG, 32'h0, 32'hF0FF);
      rd(`OFS_STATUS, stat());
      do_reset();
      rd(`OFS_STATUS, stat());
      rd(`OFS_ACC, 32'h0);
      repeat (2) @(posedge aclk);
      final_report();
   end
endmodule

bind clear_complement_compare_ops ccc_ops_properties i_chk (.aclk,
   .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
   .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
   .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
   .timeout_status_n, .powerdown_status_n);
